// File: hdl/slg_consts.vh
/*
  Constants for the stack limit and RAM guard block.
  Assumes a 16-bit data space with byte addresses and word-aligned stack.
*/
`ifndef SLG_CONSTS_VH
`define SLG_CONSTS_VH

`define SLG_DW          16
`define SLG_WORD_STEP   16'h0002
`define SLG_SFR_TOP     16'h0800
`define SLG_ALIGN_MASK  16'hfffe
`define SLG_SP_RESET    16'h0800
`define SLG_PC_MSB_W    8
`define SLG_PC_TOP_BIT  7
`define SLG_ZERO16      16'h0000

`endif

// File: hdl/slg_stack_guard.v
/*
  Stack pointer management, stack-error checking and secure RAM guard.
  Assumes the core presents one stack operation or one stack-pointer-based
  access per cycle, and names which flash segment the current code runs from.
*/
// What this block does
// - Stack pointer points at first free word, grows upward
// - Pop predecrements then reads; push writes then increments
// - Call push zero-extends counter MSB bits 6:0; MSB bit 7 is cleared
// - Exception push pairs status low byte with MSB
// - Limit register sets upper bound, no reset value
// - Limit register bit 0 reads zero once the limit is loaded
// - Every stack-pointer address compared against limit
// - Push at limit passes; next push traps
// - Stack address below 0x0800 raises underflow trap
// - Boot secure RAM only from boot flash code
// - Secure segment RAM only from secure flash code
`include "slg_consts.vh"

module slg_stack_guard (
  input  wire        clk,
  input  wire        nrst,
  input  wire        spWriteEn,
  input  wire [15:0] spWriteData,
  input  wire        limitWriteEn,
  input  wire [15:0] limitWriteData,
  input  wire        pushReq,
  input  wire        popReq,
  input  wire [1:0]  pushKind,
  input  wire [15:0] pushData,
  input  wire [7:0]  pcMsb,
  input  wire [7:0]  status_low_byte,
  input  wire        spEaValid,
  input  wire [15:0] spEa,
  input  wire        ramAccess,
  input  wire [15:0] ramAddr,
  input  wire        bootRamProtEn,
  input  wire [15:0] bootRamStart,
  input  wire [15:0] bootRamEnd,
  input  wire        secRamProtEn,
  input  wire [15:0] secRamStart,
  input  wire [15:0] secRamEnd,
  input  wire        execFromBoot,
  input  wire        execFromSecure,
  output reg  [15:0] stack_pointer_reg,
  output reg  [15:0] stack_limit_reg,
  output reg         stackMemWrite,
  output reg         stackMemRead,
  output reg  [15:0] stackMemAddr,
  output reg  [15:0] stackMemWData,
  output reg         stackErrTrap,
  output reg         ramAccessGrant,
  output reg         ramAccessBlocked
);

  // ----------------------------------------------------------------
  // Push kinds and segment indices
  // ----------------------------------------------------------------
  localparam [1:0]   KIND_DATA = 2'h0;
  localparam [1:0]   KIND_CALL = 2'h1;
  localparam [1:0]   KIND_EXC  = 2'h2;

  localparam integer SEG_COUNT = 2;
  localparam integer SEG_BOOT  = 0;
  localparam integer SEG_SEC   = 1;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Inclusive window test, shared by both protected segments.
  function inRange;
    input [15:0] addr;
    input [15:0] lo;
    input [15:0] hi;
    begin
      inRange = (addr >= lo) && (addr <= hi);
    end
  endfunction

  // Word alignment for the pointer load and the limit load alike.
  function [15:0] alignWord;
    input [15:0] value;
    begin
      alignWord = value & `SLG_ALIGN_MASK;
    end
  endfunction

  // Push at the limit itself passes; only an address beyond it traps.
  function aboveLimit;
    input [15:0] addr;
    input [15:0] limit;
    begin
      aboveLimit = addr > limit;
    end
  endfunction

  // Keeps the stack out of the special-function register space.
  function belowFloor;
    input [15:0] addr;
    begin
      belowFloor = addr < `SLG_SFR_TOP;
    end
  endfunction

  // ----------------------------------------------------------------
  // Stack operation decode
  // ----------------------------------------------------------------
  // A pointer load wins over a push or pop in the same cycle, and the
  // losing operation must neither touch memory nor raise a trap.
  wire        pointerLoad;
  wire        doPush;
  wire        doPop;
  wire        stackOp;
  wire        otherEa;
  wire [15:0] pushAddr;
  wire [15:0] popAddr;

  assign pointerLoad = spWriteEn;
  assign doPush      = pushReq & ~popReq & ~spWriteEn;
  assign doPop       = popReq & ~pushReq & ~spWriteEn;
  assign stackOp     = doPush | doPop;
  assign otherEa     = spEaValid & ~stackOp;
  assign pushAddr    = stack_pointer_reg;
  assign popAddr     = stack_pointer_reg - `SLG_WORD_STEP;

  // ----------------------------------------------------------------
  // Pushed word
  // ----------------------------------------------------------------
  reg  [15:0] pushWord;

  always @* begin
    pushWord = pushData;
    case (pushKind)
      KIND_CALL: begin
        pushWord = {{`SLG_PC_MSB_W{1'b0}}, 1'b0, pcMsb[`SLG_PC_TOP_BIT-1:0]};
      end
      KIND_EXC: begin
        pushWord = {status_low_byte, pcMsb};
      end
      KIND_DATA: begin
        pushWord = pushData;
      end
      default: begin
        pushWord = pushData;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Next pointer and operation address
  // ----------------------------------------------------------------
  reg  [15:0] stack_pointer_next;
  reg  [15:0] opAddr;

  always @* begin
    stack_pointer_next = stack_pointer_reg;
    opAddr             = stack_pointer_reg;
    if (pointerLoad) begin
      stack_pointer_next = alignWord(spWriteData);
    end else if (doPush) begin
      opAddr             = pushAddr;
      stack_pointer_next = stack_pointer_reg + `SLG_WORD_STEP;
    end else if (doPop) begin
      opAddr             = popAddr;
      stack_pointer_next = popAddr;
    end
  end

  // ----------------------------------------------------------------
  // Stack bounds checking
  // ----------------------------------------------------------------
  // Until software loads the limit the overflow result is unknown.
  reg         overflowHit;
  reg         underflowHit;
  wire        trapNext;

  always @* begin
    overflowHit  = 1'b0;
    underflowHit = 1'b0;
    if (stackOp) begin
      overflowHit  = aboveLimit(opAddr, stack_limit_reg);
      underflowHit = belowFloor(opAddr);
    end else if (otherEa) begin
      overflowHit  = aboveLimit(spEa, stack_limit_reg);
      underflowHit = belowFloor(spEa);
    end
  end

  assign trapNext = overflowHit | underflowHit;

  // ----------------------------------------------------------------
  // Secure RAM guard
  // ----------------------------------------------------------------
  wire [SEG_COUNT-1:0]          segProtEn;
  wire [SEG_COUNT-1:0]          segExecOwn;
  wire [SEG_COUNT*`SLG_DW-1:0]  segStart;
  wire [SEG_COUNT*`SLG_DW-1:0]  segEnd;
  wire [SEG_COUNT-1:0]          segDeny;
  wire                          ramDeny;

  assign segProtEn[SEG_BOOT]                       = bootRamProtEn;
  assign segProtEn[SEG_SEC]                        = secRamProtEn;
  assign segExecOwn[SEG_BOOT]                      = execFromBoot;
  assign segExecOwn[SEG_SEC]                       = execFromSecure;
  assign segStart[SEG_BOOT*`SLG_DW +: `SLG_DW]     = bootRamStart;
  assign segStart[SEG_SEC*`SLG_DW +: `SLG_DW]      = secRamStart;
  assign segEnd[SEG_BOOT*`SLG_DW +: `SLG_DW]       = bootRamEnd;
  assign segEnd[SEG_SEC*`SLG_DW +: `SLG_DW]        = secRamEnd;

  // Each segment is open only to code from its own flash segment.
  genvar seg;
  generate
    for (seg = 0; seg < SEG_COUNT; seg = seg + 1) begin : g_seg
      assign segDeny[seg] = segProtEn[seg]
                          & inRange(ramAddr,
                                    segStart[seg*`SLG_DW +: `SLG_DW],
                                    segEnd[seg*`SLG_DW +: `SLG_DW])
                          & ~segExecOwn[seg];
    end
  endgenerate

  assign ramDeny = |segDeny;

  // ----------------------------------------------------------------
  // Stack pointer register
  // ----------------------------------------------------------------
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stack_pointer_reg <= `SLG_SP_RESET;
    end else begin
      stack_pointer_reg <= stack_pointer_next;
    end
  end

  // ----------------------------------------------------------------
  // Stack memory strobes
  // ----------------------------------------------------------------
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stackMemWrite <= 1'b0;
      stackMemRead  <= 1'b0;
    end else begin
      stackMemWrite <= doPush;
      stackMemRead  <= doPop;
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stackMemAddr  <= `SLG_ZERO16;
      stackMemWData <= `SLG_ZERO16;
    end else begin
      stackMemAddr  <= opAddr;
      stackMemWData <= pushWord;
    end
  end

  // ----------------------------------------------------------------
  // Trap request
  // ----------------------------------------------------------------
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stackErrTrap <= 1'b0;
    end else begin
      stackErrTrap <= trapNext;
    end
  end

  // ----------------------------------------------------------------
  // RAM access verdict
  // ----------------------------------------------------------------
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ramAccessGrant   <= 1'b0;
      ramAccessBlocked <= 1'b0;
    end else begin
      ramAccessGrant   <= ramAccess & ~ramDeny;
      ramAccessBlocked <= ramAccess & ramDeny;
    end
  end

  // ----------------------------------------------------------------
  // Stack limit register
  // ----------------------------------------------------------------
  // Limit is deliberately left out of reset: software must load it.
  always @(posedge clk) begin
    if (limitWriteEn) begin
      stack_limit_reg <= alignWord(limitWriteData);
    end
  end

endmodule // slg_stack_guard

// File: testbench/slg_stack_guard_asserts.sv
/* Port checker for the stack guard.
   Assumes one core clock and an async active-low reset. */
module slg_checker(
  input logic clk, nrst, pushReq, popReq, spWriteEn, limitWriteEn,
  input logic spEaValid, ramAccess, stackMemWrite, stackMemRead,
  input logic stackErrTrap, ramAccessBlocked,
  input logic [1:0] pushKind,
  input logic [7:0] pcMsb, status_low_byte,
  input logic [15:0] limitWriteData, stack_pointer_reg, stack_limit_reg,
  input logic [15:0] stackMemAddr, stackMemWData);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  wire pu = pushReq & ~popReq & ~spWriteEn;
  wire po = popReq & ~pushReq & ~spWriteEn;
  wire [15:0] sp = stack_pointer_reg;
  property p_push; pu |=> stackMemWrite && stackMemAddr == $past(sp)
    && sp == $past(sp) + 16'h0002; endproperty
  a_push: assert property (p_push) else $error("push");
  property p_pop; po |=> stackMemRead && stackMemAddr == $past(sp) - 16'h0002; endproperty
  a_pop: assert property (p_pop) else $error("pop");
  property p_call; pu && pushKind == 2'h1 |=> stackMemWData == {9'h000, $past(pcMsb[6:0])};
  endproperty
  a_call: assert property (p_call) else $error("call word");
  property p_exc; pu && pushKind == 2'h2 |=>
    stackMemWData == {$past(status_low_byte), $past(pcMsb)}; endproperty
  a_exc: assert property (p_exc) else $error("exception word");
  property p_lim; limitWriteEn |=> stack_limit_reg == {$past(limitWriteData[15:1]), 1'b0};
  endproperty
  a_lim: assert property (p_lim) else $error("limit");
  property p_ovf; pu && sp > stack_limit_reg |=> stackErrTrap; endproperty
  a_ovf: assert property (p_ovf) else $error("overflow");
  property p_pass; pu && sp <= stack_limit_reg && sp >= 16'h0800 |=> !stackErrTrap; endproperty
  a_pass: assert property (p_pass) else $error("false trap");
  property p_und; po && sp < 16'h0802 |=> stackErrTrap; endproperty
  a_und: assert property (p_und) else $error("underflow");
  property p_ram; ramAccessBlocked |-> $past(ramAccess); endproperty
  a_ram: assert property (p_ram) else $error("block");
endmodule // slg_checker
bind slg_stack_guard slg_checker i_chk(.*);

// File: testbench/slg_core_model.sv
/* Exception-side model: counts stack-error trap requests.
   Assumes the core clock and reset of the guard. */
module slg_core_model(input logic clk, nrst, stackErrTrap, output logic [7:0] trapCount);
  always @(posedge clk or negedge nrst)
    if (!nrst) trapCount <= 8'h00;
    else if (stackErrTrap) trapCount <= trapCount + 8'h01;
endmodule // slg_core_model

// File: testbench/slg_stack_guard_tb.sv
/* Self-checking bench for the stack guard.
   Assumes the checker is bound and the core model counts traps. */
module slg_stack_guard_tb;
  timeunit 1ns; timeprecision 1ns;
  logic clk = 0, nrst = 0, spWriteEn = 0, limitWriteEn = 0, pushReq = 0, popReq = 0;
  logic spEaValid = 0, ramAccess = 0, bootRamProtEn = 0, secRamProtEn = 0;
  logic execFromBoot = 0, execFromSecure = 0, stackMemWrite, stackMemRead, stackErrTrap;
  logic ramAccessGrant, ramAccessBlocked;
  logic [1:0] pushKind = 0;
  logic [7:0] pcMsb = 0, status_low_byte = 0, trapCount;
  logic [15:0] spWriteData = 0, limitWriteData = 0, pushData = 0, spEa = 0, ramAddr = 0;
  logic [15:0] bootRamStart = 16'h1000, bootRamEnd = 16'h10ff, secRamStart = 16'h2000;
  logic [15:0] secRamEnd = 16'h20ff, stack_pointer_reg, stack_limit_reg;
  logic [15:0] stackMemAddr, stackMemWData;
  int mismatches = 0, compares = 0;
  // Kind, data, pc/status, expected word, expected trap
  logic [50:0] rows [4] = '{{2'h0, 16'h1234, 16'h0000, 16'h1234, 1'b0},
    {2'h1, 16'h0000, 16'hff00, 16'h007f, 1'b0}, {2'h2, 16'h0000, 16'habcd, 16'hcdab, 1'b0},
    {2'h3, 16'h5a5a, 16'h0000, 16'h5a5a, 1'b1}};
  always #10 clk = ~clk;
  slg_stack_guard i_dut(.*);
  slg_core_model i_core(.*);
  task chk(input logic [15:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task op(input logic pu, po, input logic [1:0] k, input logic [15:0] d, ps);
    @(posedge clk);
    pushReq <= pu; popReq <= po; pushKind <= k; pushData <= d;
    {pcMsb, status_low_byte} <= ps;
    @(posedge clk);
    pushReq <= 0; popReq <= 0; #1;
  endtask
  task conclude;
    if (mismatches == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1; limitWriteEn <= 1; limitWriteData <= 16'h0805;
    @(posedge clk);
    limitWriteEn <= 0; #1 chk(stack_pointer_reg, 16'h0800);
    chk(stack_limit_reg, 16'h0804);
    foreach (rows[i]) begin
      op(1, 0, rows[i][50:49], rows[i][48:33], rows[i][32:17]);
      chk(stackMemAddr, 16'h0802 - 16'h0002 + 16'h0002 * i);
      chk(stackMemWData, rows[i][16:1]);
      chk(stackErrTrap, rows[i][0]);
    end
    op(1, 1, 0, 0, 0);
    chk({stackMemWrite, stackMemRead}, 0);
    op(0, 1, 0, 0, 0);
    chk(stackMemAddr, 16'h0806);
    chk(stackMemRead, 1);
    chk(stackErrTrap, 1);
    @(posedge clk);
    spWriteEn <= 1; spWriteData <= 16'h0803;
    @(posedge clk);
    spWriteEn <= 0; #1 chk(stack_pointer_reg, 16'h0802);
    op(0, 1, 0, 0, 0);
    chk(stackErrTrap, 0);
    op(0, 1, 0, 0, 0);
    chk(stackErrTrap, 1);
    @(posedge clk);
    spEaValid <= 1; spEa <= 16'h0900;
    @(posedge clk);
    spEaValid <= 0; #1 chk(stackErrTrap, 1);
    @(posedge clk);
    #1 chk(trapCount, 8'h04);
    for (int e = 0; e < 4; e++) begin
      @(posedge clk);
      ramAccess <= 1; bootRamProtEn <= 1; secRamProtEn <= 1;
      ramAddr <= e[1] ? 16'h2010 : 16'h1010;
      execFromBoot <= e[0] & ~e[1]; execFromSecure <= e[0] & e[1];
      @(posedge clk);
      ramAccess <= 0; #1 chk({ramAccessGrant, ramAccessBlocked}, {e[0], ~e[0]});
    end
    @(posedge clk);
    ramAccess <= 1; ramAddr <= 16'h1010; execFromBoot <= 0; execFromSecure <= 1;
    @(posedge clk);
    ramAccess <= 0; #1 chk({ramAccessGrant, ramAccessBlocked}, 2'h1);
    @(posedge clk);
    ramAccess <= 1; bootRamProtEn <= 0;
    @(posedge clk);
    ramAccess <= 0; #1 chk({ramAccessGrant, ramAccessBlocked}, 2'h2);
    @(posedge clk);
    nrst <= 0;
    @(posedge clk);
    #1 chk(stack_pointer_reg, 16'h0800);
    chk(stack_limit_reg, 16'h0804);
    chk(stackErrTrap, 0);
    nrst <= 1;
    conclude;
  end
endmodule // slg_stack_guard_tb
